/* rtl/ats_pkg.sv */
// package: constants and types for the acquisition trigger sequencer
package ats_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ATS_CTRL_OFS = 8'h00;
   localparam logic [7:0] ATS_FCNT_OFS = 8'h04;
   localparam logic [7:0] ATS_PER_OFS = 8'h08;
   localparam logic [7:0] ATS_MINP_OFS = 8'h0c;
   localparam logic [7:0] ATS_EXP_OFS = 8'h10;
   localparam logic [7:0] ATS_XMIT_OFS = 8'h14;
   localparam logic [7:0] ATS_STAT_OFS = 8'h18;
   localparam logic [7:0] ATS_DONE_OFS = 8'h1c;
   // ---------------------------------------------------------------
   // control field positions
   // ---------------------------------------------------------------
   localparam int ATS_CTRL_ENABLE = 0;
   localparam int ATS_CTRL_ACQ_EXT = 1;
   localparam int ATS_CTRL_FRM_EXT = 2;
   localparam int ATS_CTRL_RATE_EN = 3;
   localparam int ATS_CTRL_SINGLE = 4;
   localparam int ATS_CTRL_ACQ_FALL = 5;
   localparam int ATS_CTRL_FRM_FALL = 6;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [6:0] ATS_CTRL_RST = 7'h00;
   localparam logic [15:0] ATS_FCNT_RST = 16'h0003;
   localparam logic [31:0] ATS_PER_RST = 32'h0001_e848;
   localparam logic [31:0] ATS_MINP_RST = 32'h0000_0400;
   localparam logic [31:0] ATS_EXP_RST = 32'h0000_0100;
   localparam logic [31:0] ATS_XMIT_RST = 32'h0000_0200;
   // internal setup time before each single-frame exposure started by the internal timer
   localparam int ATS_SETUP_NS = 800;
   localparam int ATS_CLK_NS = 8;
   localparam logic [31:0] ATS_SETUP_CYC = 32'((ATS_SETUP_NS + ATS_CLK_NS - 1) / ATS_CLK_NS);
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ATS_WAIT_ACQ = 3'b001,
      ATS_WAIT_FRM = 3'b010,
      ATS_SETUP = 3'b100
   } ats_state_t;

   typedef struct packed {
      logic exposing;
      logic transmitting;
      logic wait_acq;
      logic wait_frm;
   } ats_status_t;
endpackage

/* rtl/ats_sequencer.sv */
// module: acquisition and frame start trigger sequencer with an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none

module ats_sequencer (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // trigger input lines
   input wire logic acq_line,
   input wire logic frm_line,
   // pipeline stage outputs
   output logic frame_start,
   output logic exposure_active,
   output logic transmit_active,
   output ats_pkg::ats_status_t status
);
   import ats_pkg::*;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [6:0] ctrl_q;
   logic [15:0] fcnt_q;
   logic [31:0] per_q;
   logic [31:0] minp_q;
   logic [31:0] exp_q;
   logic [31:0] xmit_q;
   logic [31:0] done_q;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic edge_seen(input logic cur, input logic prev, input logic fall);
      return fall ? (prev & ~cur) : (cur & ~prev);
   endfunction

   // ---------------------------------------------------------------
   // axi4-lite write channel
   // ---------------------------------------------------------------
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;

   // address and data may arrive in either order
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready;
         s_axi_wready <= !w_held_q && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            unique case (awaddr_q)
               ATS_CTRL_OFS, ATS_FCNT_OFS, ATS_PER_OFS, ATS_MINP_OFS,
               ATS_EXP_OFS, ATS_XMIT_OFS: s_axi_bresp <= 2'b00;
               default: s_axi_bresp <= 2'b10;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   logic [31:0] ctrl_wr;
   logic [31:0] fcnt_wr;

   // narrow registers merge at full width, then get cut back to their size
   assign ctrl_wr = merge({25'h0, ctrl_q}, wdata_q, wstrb_q);
   assign fcnt_wr = merge({16'h0, fcnt_q}, wdata_q, wstrb_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= ATS_CTRL_RST;
         fcnt_q <= ATS_FCNT_RST;
         per_q <= ATS_PER_RST;
         minp_q <= ATS_MINP_RST;
         exp_q <= ATS_EXP_RST;
         xmit_q <= ATS_XMIT_RST;
      end else if (do_write) begin
         unique case (awaddr_q)
            ATS_CTRL_OFS: ctrl_q <= ctrl_wr[6:0];
            ATS_FCNT_OFS: fcnt_q <= fcnt_wr[15:0];
            ATS_PER_OFS: per_q <= merge(per_q, wdata_q, wstrb_q);
            ATS_MINP_OFS: minp_q <= merge(minp_q, wdata_q, wstrb_q);
            ATS_EXP_OFS: exp_q <= merge(exp_q, wdata_q, wstrb_q);
            ATS_XMIT_OFS: xmit_q <= merge(xmit_q, wdata_q, wstrb_q);
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read channel
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            unique case (s_axi_araddr)
               ATS_CTRL_OFS: s_axi_rdata <= {25'h0, ctrl_q};
               ATS_FCNT_OFS: s_axi_rdata <= {16'h0, fcnt_q};
               ATS_PER_OFS: s_axi_rdata <= per_q;
               ATS_MINP_OFS: s_axi_rdata <= minp_q;
               ATS_EXP_OFS: s_axi_rdata <= exp_q;
               ATS_XMIT_OFS: s_axi_rdata <= xmit_q;
               ATS_STAT_OFS: s_axi_rdata <= {28'h0, status};
               ATS_DONE_OFS: s_axi_rdata <= done_q;
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // trigger edge detection
   // ---------------------------------------------------------------
   logic acq_prev_q;
   logic frm_prev_q;
   logic acq_edge;
   logic frm_edge;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acq_prev_q <= 1'b0;
         frm_prev_q <= 1'b0;
      end else begin
         acq_prev_q <= acq_line;
         frm_prev_q <= frm_line;
      end
   end

   assign acq_edge = edge_seen(acq_line, acq_prev_q, ctrl_q[ATS_CTRL_ACQ_FALL]);
   assign frm_edge = edge_seen(frm_line, frm_prev_q, ctrl_q[ATS_CTRL_FRM_FALL]);

   // ---------------------------------------------------------------
   // internal frame start timer
   // ---------------------------------------------------------------
   logic [31:0] tmr_q;
   logic [31:0] period;
   logic int_tick;
   logic stage_busy;
   logic tick_taken;

   // with rate control on, slower of the setpoint and the settings-imposed minimum period; the minimum alone otherwise
   assign period = (ctrl_q[ATS_CTRL_RATE_EN] && per_q > minp_q) ? per_q : minp_q;
   assign int_tick = (tmr_q == 32'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_q[ATS_CTRL_ENABLE]) begin
         tmr_q <= 32'h0;
      end else if (int_tick) begin
         // reload on the very edge the tick is used, else it would start two frames
         if (tick_taken) begin
            tmr_q <= period - 32'h1;
         end
      end else begin
         tmr_q <= tmr_q - 32'h1;
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   ats_state_t state_q;
   logic [15:0] frames_q;
   logic [31:0] setup_q;
   logic frm_req;
   logic acq_req;

   assign acq_req = ctrl_q[ATS_CTRL_ACQ_EXT] ? acq_edge : 1'b1;
   // single-frame mode waits for the exposure and transmission to finish
   assign stage_busy = ctrl_q[ATS_CTRL_SINGLE] && (exposure_active || transmit_active);
   assign frm_req = ctrl_q[ATS_CTRL_FRM_EXT] ? frm_edge : (int_tick && !stage_busy);
   // ticks seen while waiting for acquisition are left pending, not consumed
   assign tick_taken = frm_req && !ctrl_q[ATS_CTRL_FRM_EXT]
                       && (state_q == ATS_WAIT_FRM);

   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_q[ATS_CTRL_ENABLE]) begin
         state_q <= ATS_WAIT_ACQ;
         frames_q <= 16'h0;
         setup_q <= 32'h0;
         frame_start <= 1'b0;
      end else begin
         frame_start <= 1'b0;
         unique case (state_q)
            ATS_WAIT_ACQ: begin
               // external frame start edges seen here are dropped; internal ticks stay pending
               if (acq_req) begin
                  state_q <= ATS_WAIT_FRM;
                  frames_q <= 16'h0;
               end
            end
            ATS_WAIT_FRM: begin
               if (frm_req && ctrl_q[ATS_CTRL_SINGLE] && !ctrl_q[ATS_CTRL_FRM_EXT]) begin
                  state_q <= ATS_SETUP;
                  setup_q <= ATS_SETUP_CYC;
               end else if (frm_req && !stage_busy) begin
                  frame_start <= 1'b1;
                  frames_q <= frames_q + 16'h1;
                  if (frames_q + 16'h1 >= fcnt_q) begin
                     state_q <= ATS_WAIT_ACQ;
                  end
               end
            end
            ATS_SETUP: begin
               setup_q <= setup_q - 32'h1;
               if (setup_q == 32'h1) begin
                  frame_start <= 1'b1;
                  frames_q <= frames_q + 16'h1;
                  state_q <= (frames_q + 16'h1 >= fcnt_q) ? ATS_WAIT_ACQ : ATS_WAIT_FRM;
               end
            end
            default: state_q <= ATS_WAIT_ACQ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // exposure/readout then transmission stage timing
   // ---------------------------------------------------------------
   logic [31:0] exp_cnt_q;
   logic [31:0] xmit_cnt_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exp_cnt_q <= 32'h0;
         xmit_cnt_q <= 32'h0;
         exposure_active <= 1'b0;
         transmit_active <= 1'b0;
         done_q <= 32'h0;
         status <= '0;
      end else begin
         if (frame_start) begin
            exposure_active <= 1'b1;
            exp_cnt_q <= exp_q;
         end else if (exposure_active) begin
            exp_cnt_q <= exp_cnt_q - 32'h1;
            if (exp_cnt_q <= 32'h1) begin
               exposure_active <= 1'b0;
               transmit_active <= 1'b1;
               xmit_cnt_q <= xmit_q;
            end
         end
         if (transmit_active && !(exposure_active && exp_cnt_q <= 32'h1)) begin
            xmit_cnt_q <= xmit_cnt_q - 32'h1;
            if (xmit_cnt_q <= 32'h1) begin
               transmit_active <= 1'b0;
               done_q <= done_q + 32'h1;
            end
         end
         status.exposing <= exposure_active;
         status.transmitting <= transmit_active;
         status.wait_acq <= (state_q == ATS_WAIT_ACQ);
         status.wait_frm <= (state_q != ATS_WAIT_ACQ);
      end
   end
endmodule

`default_nettype wire

/* test/ats_assertions.sv */
// checker: handshake and frame timing assertions for the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module ats_assertions (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus answers
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pipeline
   input wire logic frame_start,
   input wire logic exposure_active,
   input wire logic transmit_active,
   input wire ats_pkg::ats_status_t status
);
   import ats_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----
   // frame stages
   // ----
   sequence expose_s; ##[0:2] exposure_active; endsequence
   sequence send_s; ##[0:2] transmit_active; endsequence
   pulse_one_a: assert property (frame_start |=> !frame_start)
      else $error("frame start wider than one cycle");
   idle_quiet_a: assert property (status.wait_acq && $past(status.wait_acq) |-> !frame_start)
      else $error("frame started while waiting for acquisition");
   one_state_a: assert property ($past(aresetn) |-> status.wait_acq != status.wait_frm)
      else $error("waiting states not exclusive");
   expose_after_a: assert property (frame_start |-> expose_s)
      else $error("no exposure after frame start");
   send_after_a: assert property ($fell(exposure_active) |-> send_s)
      else $error("no transmission after exposure");
   // ----
   // bus answers
   // ----
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
endmodule
`default_nettype wire

/* test/ats_trigger_src.sv */
// model: external trigger source driving the two input lines
`timescale 1ns/1ps
`default_nettype none
module ats_trigger_src (
   // clock
   input wire logic aclk,
   // pulse requests
   input wire logic acq_go,
   input wire logic frm_go,
   // push-pull lines, low when idle
   output logic acq_line,
   output logic frm_line
);
   logic [2:0] acq_q = 3'h0;
   logic [2:0] frm_q = 3'h0;
   // four-cycle pulses: one rising and one falling edge per request
   always_ff @(posedge aclk) acq_q <= acq_go ? 3'h4 : acq_q - 3'(acq_q != 3'h0);
   always_ff @(posedge aclk) frm_q <= frm_go ? 3'h4 : frm_q - 3'(frm_q != 3'h0);
   assign acq_line = acq_q != 3'h0;
   assign frm_line = frm_q != 3'h0;
endmodule
`default_nettype wire

/* test/tb.sv */
// testbench: registers, trigger use cases and reset of the sequencer
`timescale 1ns/1ps
`default_nettype none
bind ats_sequencer ats_assertions ats_assertions_i (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .frame_start(frame_start), .exposure_active(exposure_active),
   .transmit_active(transmit_active), .status(status));
module tb;
   import ats_pkg::*;
   typedef struct {logic [6:0] c; logic [15:0] f; logic [31:0] p; int na, nf, lo, hi;} ats_row_t;
   logic aclk, aresetn, awv, wv, bre, arv, rre, acq_go, frm_go, busy_p;
   logic [7:0] awa, ara;
   logic [31:0] wd, d;
   logic [1:0] r;
   wire logic aw_r, w_r, b_v, ar_r, r_v, fs, ea, ta, acq_line, frm_line;
   wire logic [1:0] b_r, r_r;
   wire logic [31:0] r_d;
   wire ats_status_t st;
   int n_mismatch, total_checks, seen, ovl;
   logic [7:0] ofs[6] = '{ATS_CTRL_OFS, ATS_FCNT_OFS, ATS_PER_OFS, ATS_MINP_OFS, ATS_EXP_OFS,
      ATS_XMIT_OFS};
   logic [31:0] rv[6] = '{32'(ATS_CTRL_RST), 32'(ATS_FCNT_RST), ATS_PER_RST, ATS_MINP_RST,
      ATS_EXP_RST, ATS_XMIT_RST};
   // ctrl, frame count, period, acq pulses, frame pulses, min and max frames
   ats_row_t rows[11] = '{
      '{7'h01, 16'd3, 32'd80, 0, 0, 27, 31},
      '{7'h09, 16'd3, 32'd80, 0, 0, 13, 16},
      '{7'h09, 16'd3, 32'd20, 0, 0, 27, 31},
      '{7'h05, 16'd3, 32'd80, 0, 10, 10, 10},
      '{7'h45, 16'd3, 32'd80, 0, 10, 10, 10},
      '{7'h03, 16'd3, 32'd80, 1, 0, 3, 3},
      '{7'h03, 16'd3, 32'd80, 2, 0, 6, 6},
      '{7'h23, 16'd1, 32'd80, 1, 0, 1, 1},
      '{7'h03, 16'd0, 32'd80, 1, 0, 1, 1},
      '{7'h13, 16'd3, 32'd80, 1, 0, 3, 3},
      '{7'h03, 16'd3, 32'd80, 0, 10, 0, 0}};
   ats_sequencer ats_sequencer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(w_r), .s_axi_bresp(b_r), .s_axi_bvalid(b_v),
      .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_r),
      .s_axi_rdata(r_d), .s_axi_rresp(r_r), .s_axi_rvalid(r_v), .s_axi_rready(rre),
      .acq_line(acq_line), .frm_line(frm_line), .frame_start(fs), .exposure_active(ea),
      .transmit_active(ta), .status(st));
   ats_trigger_src ats_trigger_src_i (.aclk(aclk), .acq_go(acq_go), .frm_go(frm_go),
      .acq_line(acq_line), .frm_line(frm_line));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // frames seen, and frames launched while the previous one still ran
   always @(posedge aclk) begin
      if (fs === 1'b1) seen++;
      if (fs === 1'b1 && busy_p) ovl++;
      busy_p = ea | ta;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // bready and rready stay high; only the watchdog ends a wait for an answer
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge aclk);
         if (awv && aw_r) awv <= 1'b0;
         if (wv && w_r) wv <= 1'b0;
      end while (b_v !== 1'b1);
      rs = b_r;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      ara <= a;
      arv <= 1'b1;
      do begin
         @(posedge aclk);
         if (arv && ar_r) arv <= 1'b0;
      end while (r_v !== 1'b1);
      v = r_d;
      rs = r_r;
   endtask
   initial begin
      repeat (30000) @(posedge aclk);
      n_mismatch++;
      conclude();
   end
   initial begin
      aresetn = 1'b0; awv = 1'b0; wv = 1'b0; bre = 1'b1; arv = 1'b0; rre = 1'b1;
      acq_go = 1'b0; frm_go = 1'b0; awa = 8'h00; ara = 8'h00; wd = 32'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 6; i++) begin
         rd(ofs[i], d, r);
         chk(d, rv[i]);
      end
      rd(8'h20, d, r);
      chk({d[29:0], r}, 32'h2);
      wr(ATS_STAT_OFS, 32'h1, r);
      chk(r, 32'h2);
      wr(ATS_MINP_OFS, 32'd40, r);
      wr(ATS_EXP_OFS, 32'd4, r);
      wr(ATS_XMIT_OFS, 32'd8, r);
      foreach (rows[i]) begin
         wr(ATS_FCNT_OFS, 32'(rows[i].f), r);
         wr(ATS_PER_OFS, rows[i].p, r);
         seen = 0;
         wr(ATS_CTRL_OFS, 32'(rows[i].c), r);
         for (int c = 0; c < 1200; c++) begin
            @(posedge aclk);
            acq_go <= (c % 600 == 50) && (c / 600 < rows[i].na);
            frm_go <= (c % 60 == 50) && (c / 60 < rows[i].nf);
         end
         chk(32'(seen >= rows[i].lo && seen <= rows[i].hi), 32'h1);
         wr(ATS_CTRL_OFS, 32'h0, r);
         repeat (20) @(posedge aclk);
      end
      chk(ovl, 32'h0);
      // reset in the middle of free running
      wr(ATS_CTRL_OFS, 32'h1, r);
      repeat (100) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      chk({fs, ea, ta, st}, 32'h0);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(ATS_CTRL_OFS, d, r);
      chk(d, 32'h0);
      conclude();
   end
endmodule
`default_nettype wire
